// ### include/wfs_pkg.sv
// Purpose: Shared constants and types for the washer fault supervisor
// Assumes: 10 MHz system clock, synchronous active-low reset
// Notes: Long timing counts are top-level parameters; defaults derive from these
package wfs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;       // System clock rate
  localparam int unsigned FILL_LIMIT_MIN = 10;       // Fill limit in minutes
  localparam int unsigned INV_LIMIT_S = 14;          // Inverter wait in seconds
  localparam int unsigned VIB_DELAY_MIN_S = 45;      // Shortest vibration pause
  localparam int unsigned VIB_DELAY_MAX_S = 85;      // Longest vibration pause
  localparam int unsigned VIB_EXTRA_S = 60;          // Extra reverse after low level
  localparam int unsigned SEC_CYCLES = CLK_HZ;       // Cycles per second
  localparam int unsigned FILL_LIMIT_S = FILL_LIMIT_MIN * 60;
  localparam int unsigned TIMER_W = 16;              // Step timer width, seconds
  localparam int unsigned SEC_W = 10;                // Seconds counter width

  // ----------------------------------------------------------------
  // Formula counts
  // ----------------------------------------------------------------
  localparam int unsigned NUM_FORMULAS = 30;         // Formula slots
  localparam int unsigned FIDX_W = 5;                // Formula index width
  localparam logic [9:0] COUNT_MAX = 10'h3E7;        // Count saturates at 999
  localparam logic [9:0] COUNT_RST = 10'h000;        // Count reset value

  // ----------------------------------------------------------------
  // Fault codes shown on the display, lowest code has priority
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    WFS_F_NONE = 4'h0,
    WFS_F_FLASH = 4'h1,
    WFS_F_CHECKSUM = 4'h2,
    WFS_F_ACCUM = 4'h3,
    WFS_F_CTRL_PWR = 4'h4,
    WFS_F_DOOR = 4'h5,
    WFS_F_INVERTER = 4'h6,
    WFS_F_LEVEL_SW = 4'h7,
    WFS_F_LEVEL_STUCK = 4'h8,
    WFS_F_FILL = 4'h9,
    WFS_F_DRAIN = 4'hA,
    WFS_F_EXTERNAL = 4'hB,
    WFS_F_IMBALANCE = 4'hC
  } wfs_code_t;

  // Machine sensor inputs, all active high
  typedef struct packed {
    logic door_closed;     // Door closed
    logic level_low;       // Low level reached
    logic level_high;      // High level reached
    logic ctrl_power_ok;   // Latched control relay energized
    logic inverter_ok;     // Inverter running input
    logic vib_switch;      // Vibration switch closed
    logic chem_fail;       // Chemical injection failed
  } wfs_sense_t;

  // Step context from the sequencer
  typedef struct packed {
    logic running;         // Formula running
    logic formula_start;   // Pulse: formula begins
    logic filling;         // Bath fill in progress
    logic pre_fill;        // Just before a bath fill
    logic draining;        // Drain in progress
    logic extract;         // Extract or just before it
    logic formula_done;    // Pulse: formula counted
  } wfs_step_t;

  // Operator keys, one-cycle pulses
  typedef struct packed {
    logic start;
    logic next;
    logic terminate;
  } wfs_keys_t;

  // Status flags, one per fault
  typedef struct packed {
    logic flash;
    logic checksum;
    logic accum;
    logic ctrl_pwr;
    logic door;
    logic inverter;
    logic level_sw;
    logic level_stuck;
    logic fill;
    logic drain;
    logic external;
    logic imbalance;
  } wfs_flags_t;

  localparam wfs_flags_t FLAGS_RST = '0;             // No fault after reset

  // Imbalance recovery phases
  typedef enum logic [1:0] {
    WFS_V_IDLE,
    WFS_V_WAIT,
    WFS_V_REFILL,
    WFS_V_EXTRA
  } wfs_vib_t;

endpackage

// ### rtl/wfs_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage is read only by the second stage
module wfs_sync #(
  parameter int unsigned WIDTH = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;  // First stage

  // ----------------------------------------------------------------
  // Two register stages
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule

// ### rtl/wfs_top.sv
// Purpose: Fault supervision for a washer-extractor controller
// Assumes: 10 MHz clock; sequencer supplies step context; keys are pulses
// Notes: Time limits other than the drain limit are parameters so simulation can shorten them

module wfs_top #(
  parameter int unsigned SEC_CYC = wfs_pkg::SEC_CYCLES,          // Cycles per second
  parameter int unsigned FILL_S = wfs_pkg::FILL_LIMIT_S,         // Fill limit seconds
  parameter int unsigned INV_S = wfs_pkg::INV_LIMIT_S,           // Inverter limit seconds
  parameter int unsigned VIB_S = wfs_pkg::VIB_DELAY_MIN_S,       // Vibration pause seconds
  parameter int unsigned EXTRA_S = wfs_pkg::VIB_EXTRA_S          // Extra reverse seconds
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Power-up checks from the memory checker
  input wire logic check_done,
  input wire logic accum_corrupt,
  input wire logic data_invalid,
  input wire logic flash_read_err,
  // Machine pins
  input wire wfs_pkg::wfs_sense_t sense_pin,
  // Step context and keys
  input wire wfs_pkg::wfs_step_t step,
  input wire wfs_pkg::wfs_keys_t keys,
  input wire logic [wfs_pkg::FIDX_W-1:0] formula_sel,
  input wire logic [9:0] drain_limit_s,
  input wire logic [wfs_pkg::TIMER_W-1:0] step_load,
  input wire logic step_load_en,
  // Status
  output wfs_pkg::wfs_flags_t flags,
  output wfs_pkg::wfs_code_t fault_code,
  output logic run_block,
  output logic timer_frozen,
  output logic [wfs_pkg::TIMER_W-1:0] step_time,
  output logic [9:0] count_out,
  // Machine actions
  output logic machine_stop,
  output logic basket_stop,
  output logic drain_open,
  output logic reverse_wash,
  output logic admit_water,
  output logic go_extract
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wfs_pkg::wfs_sense_t sense;                 // Synchronised pins
  logic [31:0] tick_cnt_ff;                   // Divider for one-second tick
  logic tick;                                 // One-second strobe
  logic [wfs_pkg::SEC_W-1:0] fill_sec_ff;     // Fill elapsed seconds
  logic [wfs_pkg::SEC_W-1:0] drain_sec_ff;    // Drain elapsed seconds
  logic [wfs_pkg::SEC_W-1:0] inv_sec_ff;      // Seconds since formula start
  logic inv_seen_ff;                          // Inverter input seen this formula
  logic [wfs_pkg::SEC_W-1:0] vib_sec_ff;      // Imbalance phase seconds
  wfs_pkg::wfs_vib_t vib_ff;                  // Imbalance phase
  logic [9:0] counts_ff [wfs_pkg::NUM_FORMULAS];  // Per-formula counts
  logic any_run_fault;                        // A run-time fault is active
  wfs_pkg::wfs_code_t nxt_code;               // Highest-priority code

  // Pin synchroniser
  wfs_sync #(.WIDTH($bits(wfs_pkg::wfs_sense_t))) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din(sense_pin),
    .dout(sense)
  );

  // Seconds elapsed reached a limit
  function automatic logic reached(input logic [wfs_pkg::SEC_W-1:0] sec,
                                   input int unsigned lim);
    reached = (32'(sec) >= lim);
  endfunction

  // Seconds counter step, saturating
  function automatic logic [wfs_pkg::SEC_W-1:0] bump(input logic [wfs_pkg::SEC_W-1:0] sec);
    bump = (&sec) ? sec : sec + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // One-second tick
  // ----------------------------------------------------------------
  assign tick = (tick_cnt_ff == SEC_CYC - 1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power-up faults: flash and checksum latched until reset, accum until terminate
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags.flash <= 1'b0;
      flags.checksum <= 1'b0;
      flags.accum <= 1'b0;
    end else begin
      // Storage read failure latches at any time
      if (flash_read_err) begin
        flags.flash <= 1'b1;
      end
      // Invalid stored data seen by the power-up check
      if (check_done && data_invalid) begin
        flags.checksum <= 1'b1;
      end
      // Corrupt counts; a new detection wins over terminate
      if (check_done && accum_corrupt) begin
        flags.accum <= 1'b1;
      end else if (keys.terminate && flags.accum) begin
        flags.accum <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Formula counts
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < wfs_pkg::NUM_FORMULAS; i++) begin
        counts_ff[i] <= wfs_pkg::COUNT_RST;
      end
    end else if (keys.terminate && flags.accum) begin
      for (int i = 0; i < wfs_pkg::NUM_FORMULAS; i++) begin
        counts_ff[i] <= wfs_pkg::COUNT_RST;
      end
    end else if (step.formula_done && 32'(formula_sel) < wfs_pkg::NUM_FORMULAS) begin
      if (counts_ff[formula_sel] != wfs_pkg::COUNT_MAX) begin
        counts_ff[formula_sel] <= counts_ff[formula_sel] + 1'b1;
      end
    end
  end

  // Selected count out
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_out <= wfs_pkg::COUNT_RST;
    end else if (32'(formula_sel) < wfs_pkg::NUM_FORMULAS) begin
      count_out <= counts_ff[formula_sel];
    end else begin
      count_out <= wfs_pkg::COUNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // Elapsed-time counters for fill, drain and inverter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fill_sec_ff <= '0;
      drain_sec_ff <= '0;
      inv_sec_ff <= '0;
      inv_seen_ff <= 1'b0;
    end else begin
      // Fill time runs while filling short of level
      if (!step.filling || sense.level_low) begin
        fill_sec_ff <= '0;
      end else if (tick) begin
        fill_sec_ff <= bump(fill_sec_ff);
      end
      // Drain time runs while draining with level still present
      if (!step.draining || !sense.level_low) begin
        drain_sec_ff <= '0;
      end else if (tick) begin
        drain_sec_ff <= bump(drain_sec_ff);
      end
      // Inverter watch restarts at each formula start
      if (step.formula_start || !step.running) begin
        inv_sec_ff <= '0;
        inv_seen_ff <= 1'b0;
      end else begin
        if (sense.inverter_ok) begin
          inv_seen_ff <= 1'b1;
        end
        if (tick) begin
          inv_sec_ff <= bump(inv_sec_ff);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Run-time faults
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags.door <= 1'b0;
      flags.level_sw <= 1'b0;
      flags.level_stuck <= 1'b0;
      flags.fill <= 1'b0;
      flags.drain <= 1'b0;
      flags.external <= 1'b0;
    end else begin
      // Door: set while open, cleared by start key once closed
      if (step.running && !sense.door_closed) begin
        flags.door <= 1'b1;
      end else if (keys.start && sense.door_closed) begin
        flags.door <= 1'b0;
      end
      // High level without low level is inconsistent
      flags.level_sw <= step.running && sense.level_high && !sense.level_low;
      // Level still present before fill or around extract
      flags.level_stuck <= step.running && (step.extract || step.pre_fill)
                           && (sense.level_low || sense.level_high);
      // Fill timeout, clears when level arrives
      flags.fill <= step.filling && !sense.level_low
                    && reached(fill_sec_ff, FILL_S);
      // Drain timeout against configured limit
      flags.drain <= step.draining && sense.level_low && drain_limit_s != '0
                     && drain_sec_ff >= drain_limit_s;
      // Chemical injection failure follows the input
      flags.external <= step.running && sense.chem_fail;
    end
  end

  // ----------------------------------------------------------------
  // Control power and inverter faults, key cleared
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags.ctrl_pwr <= 1'b0;
      flags.inverter <= 1'b0;
    end else begin
      // Any drop of the relay latches; start clears only once restored
      if (!sense.ctrl_power_ok) begin
        flags.ctrl_pwr <= 1'b1;
      end else if (keys.start) begin
        flags.ctrl_pwr <= 1'b0;
      end
      // Inverter silent too long after formula start
      if (step.running && !inv_seen_ff && !sense.inverter_ok && reached(inv_sec_ff, INV_S)) begin
        flags.inverter <= 1'b1;
      end else if (keys.next) begin
        flags.inverter <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Imbalance recovery sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vib_ff <= wfs_pkg::WFS_V_IDLE;
      vib_sec_ff <= '0;
      flags.imbalance <= 1'b0;
    end else begin
      unique case (vib_ff)
        wfs_pkg::WFS_V_IDLE: begin
          vib_sec_ff <= '0;
          if (step.running && sense.vib_switch) begin
            vib_ff <= wfs_pkg::WFS_V_WAIT;
            flags.imbalance <= 1'b1;
          end
        end
        wfs_pkg::WFS_V_WAIT: begin
          // Pause before reversing
          if (reached(vib_sec_ff, VIB_S)) begin
            vib_ff <= wfs_pkg::WFS_V_REFILL;
            vib_sec_ff <= '0;
          end else if (tick) begin
            vib_sec_ff <= bump(vib_sec_ff);
          end
        end
        wfs_pkg::WFS_V_REFILL: begin
          // Reverse and fill until low level
          if (sense.level_low) begin
            vib_ff <= wfs_pkg::WFS_V_EXTRA;
            vib_sec_ff <= '0;
          end
        end
        wfs_pkg::WFS_V_EXTRA: begin
          // One more minute, then on to extract
          if (reached(vib_sec_ff, EXTRA_S)) begin
            vib_ff <= wfs_pkg::WFS_V_IDLE;
            flags.imbalance <= 1'b0;
          end else if (tick) begin
            vib_sec_ff <= bump(vib_sec_ff);
          end
        end
      endcase
      if (!step.running) begin
        vib_ff <= wfs_pkg::WFS_V_IDLE;
        flags.imbalance <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault priority and step timer
  // ----------------------------------------------------------------
  assign any_run_fault = flags.ctrl_pwr | flags.door | flags.inverter | flags.level_sw
                         | flags.level_stuck | flags.fill | flags.drain | flags.external
                         | (vib_ff == wfs_pkg::WFS_V_WAIT);

  // One code at a time, lowest code first
  always_comb begin
    nxt_code = wfs_pkg::WFS_F_NONE;
    if (flags.imbalance) nxt_code = wfs_pkg::WFS_F_IMBALANCE;
    if (flags.external) nxt_code = wfs_pkg::WFS_F_EXTERNAL;
    if (flags.drain) nxt_code = wfs_pkg::WFS_F_DRAIN;
    if (flags.fill) nxt_code = wfs_pkg::WFS_F_FILL;
    if (flags.level_stuck) nxt_code = wfs_pkg::WFS_F_LEVEL_STUCK;
    if (flags.level_sw) nxt_code = wfs_pkg::WFS_F_LEVEL_SW;
    if (flags.inverter) nxt_code = wfs_pkg::WFS_F_INVERTER;
    if (flags.door) nxt_code = wfs_pkg::WFS_F_DOOR;
    if (flags.ctrl_pwr) nxt_code = wfs_pkg::WFS_F_CTRL_PWR;
    if (flags.accum) nxt_code = wfs_pkg::WFS_F_ACCUM;
    if (flags.checksum) nxt_code = wfs_pkg::WFS_F_CHECKSUM;
    if (flags.flash) nxt_code = wfs_pkg::WFS_F_FLASH;
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_code <= wfs_pkg::WFS_F_NONE;
      run_block <= 1'b0;
      timer_frozen <= 1'b0;
      machine_stop <= 1'b0;
      basket_stop <= 1'b0;
      drain_open <= 1'b0;
      reverse_wash <= 1'b0;
      admit_water <= 1'b0;
      go_extract <= 1'b0;
    end else begin
      fault_code <= nxt_code;
      run_block <= flags.flash | flags.checksum | flags.accum;
      timer_frozen <= any_run_fault | flags.imbalance;
      machine_stop <= flags.ctrl_pwr | !sense.ctrl_power_ok;
      basket_stop <= flags.inverter | (vib_ff == wfs_pkg::WFS_V_WAIT);
      drain_open <= flags.inverter;
      reverse_wash <= (vib_ff == wfs_pkg::WFS_V_REFILL) | (vib_ff == wfs_pkg::WFS_V_EXTRA);
      admit_water <= (vib_ff == wfs_pkg::WFS_V_REFILL);
      go_extract <= (vib_ff == wfs_pkg::WFS_V_EXTRA) && reached(vib_sec_ff, EXTRA_S);
    end
  end

  // Step countdown holds while frozen
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      step_time <= '0;
    end else if (step_load_en) begin
      step_time <= step_load;
    end else if (tick && step.running && !timer_frozen && step_time != '0) begin
      step_time <= step_time - 1'b1;
    end
  end

endmodule

// ### bench/wfs_chk.sv
// Purpose: Port checks for the fault supervisor
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module from the bench top file
module wfs_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs watched
  input wire logic check_done,
  input wire logic step_load_en,
  input wire wfs_pkg::wfs_sense_t sense_pin,
  input wire wfs_pkg::wfs_step_t step,
  input wire wfs_pkg::wfs_keys_t keys,
  input wire logic [wfs_pkg::FIDX_W-1:0] formula_sel,
  // Outputs watched
  input wire wfs_pkg::wfs_flags_t flags,
  input wire logic run_block,
  input wire logic timer_frozen,
  input wire logic basket_stop,
  input wire logic drain_open,
  input wire logic [wfs_pkg::TIMER_W-1:0] step_time,
  input wire logic [9:0] count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Door open for three samples while running
  sequence s_door_open;
    (step.running && !sense_pin.door_closed)[*3];
  endsequence
  // Vibration switch held for three samples while running
  sequence s_vib_hit;
    (step.running && sense_pin.vib_switch)[*3];
  endsequence
  a_door_fault_set: assert property (s_door_open |-> ##[1:2] flags.door)
    else $error("door fault not raised");
  // Frozen on this edge and no load: the value must not move across it
  a_timer_hold: assert property (timer_frozen && !step_load_en
    |=> $stable(step_time))
    else $error("step timer moved while frozen");
  a_accum_clear: assert property (flags.accum && keys.terminate
    && !check_done |=> !flags.accum)
    else $error("accumulator fault kept after terminate");
  a_count_saturate: assert property (
    (count_out == wfs_pkg::COUNT_MAX && !keys.terminate)[*2] ##0 $stable(formula_sel)
    |=> count_out == wfs_pkg::COUNT_MAX)
    else $error("count left its ceiling");
  a_power_hold: assert property (flags.ctrl_pwr && !keys.start |=> flags.ctrl_pwr)
    else $error("control-power fault cleared without start");
  a_inv_hold: assert property (flags.inverter && !keys.next |=> flags.inverter)
    else $error("inverter fault cleared without next");
  a_inv_action: assert property (flags.inverter[*2] |-> basket_stop && drain_open)
    else $error("inverter fault without stop and drain");
  a_run_blocked: assert property (flags.flash || flags.checksum
    || flags.accum |=> run_block)
    else $error("power-up fault did not block running");
  a_vib_pause: assert property (s_vib_hit |-> ##[1:3] flags.imbalance
    ##[0:2] basket_stop)
    else $error("vibration did not stop the basket");
endmodule

// ### bench/wfs_machine.sv
// Purpose: Machine model: sensors, relay and water level
// Assumes: Bench sets wanted pin levels
// Notes: Water rises while admitted, falls when drained
module wfs_machine (
  // Clock and bench wishes
  input wire logic clock,
  input wire wfs_pkg::wfs_sense_t want,
  // Actions from the supervisor
  input wire logic admit_water, drain_open,
  // Pins to the supervisor
  output wfs_pkg::wfs_sense_t sense_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] water_ff = 4'h0; // Water height in model steps
  // Water rises with the valve, empties with the drain
  always @(posedge clock) begin
    if (drain_open)
      water_ff <= 4'h0;
    else if (admit_water && water_ff != 4'hF)
      water_ff <= water_ff + 4'h1;
  end
  // Low level reported once enough water is in
  always_comb begin
    sense_pin = want;
    sense_pin.level_low = want.level_low | (water_ff > 4'h4);
  end
endmodule

// ### bench/tb_wfs_top.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Shortened timing parameters, 10 MHz clock
// Notes: Model supplies pins; bench drives keys and step context
module tb_wfs_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst_n = 1'b0, check_done = 1'b0, accum_corrupt = 1'b0;
  logic data_invalid = 1'b0, flash_read_err = 1'b0, step_load_en = 1'b0;
  wfs_pkg::wfs_sense_t want = 7'h4C, sense_pin; // Door closed, relay and inverter on
  wfs_pkg::wfs_step_t step = '0;
  wfs_pkg::wfs_keys_t keys = '0;
  logic [4:0] formula_sel = 5'h03;
  logic [9:0] drain_limit_s = 10'h002, count_out;
  logic [15:0] step_load = 16'h0064, step_time, held;
  wfs_pkg::wfs_flags_t flags;
  wfs_pkg::wfs_code_t fault_code;
  logic run_block, timer_frozen, machine_stop, basket_stop, drain_open;
  logic reverse_wash, admit_water, go_extract;
  int failures = 0, cmp_count = 0, cycles = 0;
  always #50 clock = ~clock;
  wfs_top #(.SEC_CYC(10), .FILL_S(3), .INV_S(2), .VIB_S(2), .EXTRA_S(2)) DUT (.clock, .rst_n,
    .check_done, .accum_corrupt, .data_invalid, .flash_read_err, .sense_pin, .step, .keys,
    .formula_sel, .drain_limit_s, .step_load, .step_load_en, .flags, .fault_code, .run_block,
    .timer_frozen, .step_time, .count_out, .machine_stop, .basket_stop, .drain_open,
    .reverse_wash, .admit_water, .go_extract);
  wfs_machine u_mach (.clock, .want, .admit_water, .drain_open, .sense_pin);
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare flags and shown code; a name marks the end of a test
  task automatic cf(input logic [11:0] f, input logic [3:0] c, input string t = "");
    chk("flags", 16'(f), 16'(flags));
    chk("fault_code", 16'(c), 16'(fault_code));
    if (t != "")
      $display("test %s done", t);
  endtask
  // Pulse one key: 2 start, 1 next, 0 terminate
  task automatic key(input int k);
    cyc(1);
    keys[k] <= 1'b1;
    cyc(1);
    keys <= '0;
    cyc(3);
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 200 && s !== 1'b1; i++)
      cyc(1);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(6);
    cf(12'h100, wfs_pkg::WFS_F_CTRL_PWR);
    key(2);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "power");
    step.formula_done <= 1'b1;
    cyc(1002);
    step.formula_done <= 1'b0;
    cyc(3);
    chk("count", 16'h03E7, 16'(count_out));
    formula_sel <= 5'h1E;
    cyc(3);
    chk("count", 16'h0000, 16'(count_out));
    formula_sel <= 5'h03;
    check_done <= 1'b1;
    accum_corrupt <= 1'b1;
    cyc(1);
    check_done <= 1'b0;
    accum_corrupt <= 1'b0;
    cyc(5);
    cf(12'h200, wfs_pkg::WFS_F_ACCUM);
    chk("run_block", 16'h0001, 16'(run_block));
    key(0);
    chk("count", 16'h0000, 16'(count_out));
    cf(12'h000, wfs_pkg::WFS_F_NONE, "accum");
    step_load_en <= 1'b1;
    step.running <= 1'b1;
    cyc(1);
    step_load_en <= 1'b0;
    want.door_closed <= 1'b0;
    cyc(6);
    cf(12'h080, wfs_pkg::WFS_F_DOOR);
    held = step_time;
    cyc(40);
    chk("step_time", held, step_time);
    want.door_closed <= 1'b1;
    cyc(4);
    key(2);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "door");
    cyc(25);
    chk("timer resumed", 16'h0001, 16'(step_time < held));
    want.ctrl_power_ok <= 1'b0;
    cyc(5);
    chk("machine_stop", 16'h0001, 16'(machine_stop));
    key(2);
    want.ctrl_power_ok <= 1'b1;
    cyc(5);
    cf(12'h100, wfs_pkg::WFS_F_CTRL_PWR);
    key(2);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "relay");
    want.level_high <= 1'b1;
    cyc(6);
    cf(12'h020, wfs_pkg::WFS_F_LEVEL_SW, "levels");
    want.level_high <= 1'b0;
    want.level_low <= 1'b1;
    step.extract <= 1'b1;
    cyc(6);
    cf(12'h010, wfs_pkg::WFS_F_LEVEL_STUCK);
    step.extract <= 1'b0;
    step.pre_fill <= 1'b1;
    cyc(3);
    cf(12'h010, wfs_pkg::WFS_F_LEVEL_STUCK);
    want.level_low <= 1'b0;
    cyc(6);
    step.pre_fill <= 1'b0;
    cf(12'h000, wfs_pkg::WFS_F_NONE, "stuck");
    step.filling <= 1'b1;
    cyc(15);
    cf(12'h000, wfs_pkg::WFS_F_NONE);
    cyc(30);
    cf(12'h008, wfs_pkg::WFS_F_FILL);
    want.level_low <= 1'b1;
    cyc(5);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "fill");
    step.filling <= 1'b0;
    step.draining <= 1'b1;
    cyc(45);
    cf(12'h004, wfs_pkg::WFS_F_DRAIN);
    want.level_low <= 1'b0;
    cyc(5);
    step.draining <= 1'b0;
    cf(12'h000, wfs_pkg::WFS_F_NONE, "drain");
    want.chem_fail <= 1'b1;
    cyc(6);
    cf(12'h002, wfs_pkg::WFS_F_EXTERNAL);
    want.chem_fail <= 1'b0;
    cyc(6);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "chemical");
    want.inverter_ok <= 1'b0;
    cyc(4);
    step.formula_start <= 1'b1;
    cyc(1);
    step.formula_start <= 1'b0;
    cyc(40);
    chk("stop and drain", 16'h0001, 16'(basket_stop & drain_open));
    want.inverter_ok <= 1'b1;
    cyc(6);
    cf(12'h040, wfs_pkg::WFS_F_INVERTER);
    key(1);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "inverter");
    want.vib_switch <= 1'b1;
    cyc(6);
    want.vib_switch <= 1'b0;
    cf(12'h001, wfs_pkg::WFS_F_IMBALANCE);
    wait_hi(reverse_wash);
    chk("refill", 16'h0001, 16'(admit_water & reverse_wash));
    wait_hi(go_extract);
    chk("go_extract", 16'h0001, 16'(go_extract));
    cyc(5);
    cf(12'h000, wfs_pkg::WFS_F_NONE, "vibration");
    flash_read_err <= 1'b1;
    check_done <= 1'b1;
    data_invalid <= 1'b1;
    cyc(1);
    flash_read_err <= 1'b0;
    check_done <= 1'b0;
    data_invalid <= 1'b0;
    cyc(5);
    cf(12'hC00, wfs_pkg::WFS_F_FLASH, "storage");
    rst_n <= 1'b0;
    step <= '0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(6);
    cf(12'h100, wfs_pkg::WFS_F_CTRL_PWR, "reset");
    print_verdict();
  end
endmodule
bind wfs_top wfs_chk u_chk (.clock, .rst_n, .check_done, .step_load_en, .sense_pin, .step,
  .keys, .formula_sel, .flags, .run_block, .timer_frozen, .basket_stop, .drain_open,
  .step_time, .count_out);
